// File: common/fpes_regs.svh
// Command codes, unlock addresses and bus timing counts for the flash sequencer
`ifndef FPES_REGS_SVH
`define FPES_REGS_SVH
`define FPES_UNLOCK1_ADDR 20'h00555
`define FPES_UNLOCK2_ADDR 20'h002aa
`define FPES_UNLOCK1_DATA 8'haa
`define FPES_UNLOCK2_DATA 8'h55
`define FPES_CMD_PROG 8'ha0
`define FPES_CMD_BYPASS 8'h20
`define FPES_CMD_BYP_RST1 8'h90
`define FPES_CMD_BYP_RST2 8'h00
`define FPES_CMD_ERASE_SETUP 8'h80
`define FPES_CMD_CHIP_ERASE 8'h10
`define FPES_CMD_SECTOR_ERASE 8'h30
`define FPES_CMD_SUSPEND 8'hb0
`define FPES_CMD_RESUME 8'h30
`define FPES_CMD_RESET 8'hf0
`define FPES_CLK_NS 5
`define FPES_WE_LOW_NS 35
`define FPES_WE_HIGH_NS 20
`define FPES_SECT_WIN_US 50
`define FPES_SETTLE_CYC 3'h4
`define FPES_TIME_LIMIT_BIT 5
`endif

// File: common/fpes_pkg.sv
// Types for the flash program and erase sequencer
package fpes_pkg;
	typedef enum logic [3:0] {
		FPES_OP_PROGRAM = 4'h0,
		FPES_OP_BYPASS_ENTER = 4'h1,
		FPES_OP_BYPASS_PROGRAM = 4'h2,
		FPES_OP_BYPASS_EXIT = 4'h3,
		FPES_OP_CHIP_ERASE = 4'h4,
		FPES_OP_SECTOR_ERASE = 4'h5,
		FPES_OP_SECTOR_ADD = 4'h6,
		FPES_OP_SUSPEND = 4'h7,
		FPES_OP_RESUME = 4'h8,
		FPES_OP_RESET = 4'h9
	} fpes_op_t;
	typedef struct packed {
		fpes_op_t op;
		logic [19:0] addr;
		logic [15:0] data;
	} fpes_req_t;
	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] data;
	} fpes_cycle_t;
endpackage : fpes_pkg

// File: hdl/fpes_write_cycle.sv
// One flash write cycle: chip select and write strobe timed by a cycle counter
`timescale 1ns/100ps
`default_nettype none
`include "fpes_regs.svh"
module fpes_write_cycle #(
	parameter int LOW_CYC = (`FPES_WE_LOW_NS + `FPES_CLK_NS - 1) / `FPES_CLK_NS,
	parameter int HIGH_CYC = (`FPES_WE_HIGH_NS + `FPES_CLK_NS - 1) / `FPES_CLK_NS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	output logic busy,
	output logic strobeLow,
	output logic done
);
	logic [7:0] cnt_q;
	logic phase_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
			strobeLow <= 1'b0;
			phase_q <= 1'b0;
			cnt_q <= 8'h00;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (start) begin
					busy <= 1'b1;
					strobeLow <= 1'b1;
					phase_q <= 1'b0;
					cnt_q <= 8'(LOW_CYC - 1);
				end
			end else if (cnt_q != 8'h00) begin
				cnt_q <= cnt_q - 8'h01;
			end else if (!phase_q) begin
				// Rising strobe latches the data inside the flash
				strobeLow <= 1'b0;
				phase_q <= 1'b1;
				cnt_q <= 8'(HIGH_CYC - 1);
			end else begin
				busy <= 1'b0;
				done <= 1'b1;
			end
		end
	end
endmodule : fpes_write_cycle
`default_nettype wire

// File: hdl/fpes_host.sv
// Host controller that issues program and erase command sequences to a parallel flash
`timescale 1ns/100ps
`default_nettype none
`include "fpes_regs.svh"
module fpes_host
	import fpes_pkg::*;
#(
	parameter int ADDR_W = 20,
	parameter int WIN_CYC = (`FPES_SECT_WIN_US * 1000) / `FPES_CLK_NS,
	parameter int RST_CYC = 100
) (
	input wire logic clk,
	input wire logic nrst,
	input wire fpes_pkg::fpes_req_t reqCmd,
	input wire logic reqValid,
	output logic reqReady,
	output logic opFailed,
	output logic bypassActive,
	output logic suspended,
	output logic winOpen,
	output logic flashCeN,
	output logic flashWeN,
	output logic flashOeN,
	output logic flashResetN,
	output logic [ADDR_W-1:0] flashAddr,
	output logic [15:0] flashDataOut,
	output logic flashDataOe,
	input wire logic [15:0] flashDataIn,
	input wire logic ready_busy_n
);
	import fpes_pkg::*;
	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		FPES_IDLE = 3'b000,
		FPES_GAP = 3'b001,
		FPES_WRITE = 3'b011,
		FPES_WAIT = 3'b010,
		FPES_RESET = 3'b100
	} fpes_state_t;
	fpes_state_t state_q;
	fpes_cycle_t seq_q [6];
	logic [2:0] len_q;
	logic [2:0] idx_q;
	logic waitBusy_q;
	logic [2:0] settle_q;
	logic [31:0] win_q;
	logic [15:0] rstCnt_q;
	logic start;
	logic wcBusy;
	logic wcLow;
	logic wcDone;
	fpes_write_cycle u_wc (
		.clk(clk),
		.nrst(nrst),
		.start(start),
		.busy(wcBusy),
		.strobeLow(wcLow),
		.done(wcDone)
	);
	assign start = (state_q == FPES_GAP) && !wcBusy;
	// ------------------------------------------------------------
	// Command assembly
	// ------------------------------------------------------------
	function automatic fpes_cycle_t cyc(input logic [19:0] a, input logic [7:0] d);
		fpes_cycle_t c;
		c.addr = a;
		c.data = {8'h00, d};
		return c;
	endfunction
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= FPES_IDLE;
			len_q <= 3'h0;
			idx_q <= 3'h0;
			waitBusy_q <= 1'b0;
			settle_q <= 3'h0;
			rstCnt_q <= 16'h0000;
			for (int i = 0; i < 6; i++) begin
				seq_q[i] <= '0;
			end
		end else begin
			case (state_q)
				FPES_IDLE: begin
					if (reqValid) begin
						idx_q <= 3'h0;
						waitBusy_q <= 1'b0;
						state_q <= FPES_GAP;
						// Unlock pair shared by every full sequence
						seq_q[0] <= cyc(`FPES_UNLOCK1_ADDR, `FPES_UNLOCK1_DATA);
						seq_q[1] <= cyc(`FPES_UNLOCK2_ADDR, `FPES_UNLOCK2_DATA);
						case (reqCmd.op)
							FPES_OP_PROGRAM: begin
								seq_q[2] <= cyc(`FPES_UNLOCK1_ADDR, `FPES_CMD_PROG);
								seq_q[3] <= '{addr: reqCmd.addr, data: reqCmd.data};
								len_q <= 3'h4;
								waitBusy_q <= 1'b1;
							end
							FPES_OP_BYPASS_ENTER: begin
								seq_q[2] <= cyc(`FPES_UNLOCK1_ADDR, `FPES_CMD_BYPASS);
								len_q <= 3'h3;
							end
							FPES_OP_BYPASS_PROGRAM: begin
								seq_q[0] <= cyc(20'h00000, `FPES_CMD_PROG);
								seq_q[1] <= '{addr: reqCmd.addr, data: reqCmd.data};
								len_q <= 3'h2;
								waitBusy_q <= 1'b1;
							end
							FPES_OP_BYPASS_EXIT: begin
								seq_q[0] <= cyc(20'h00000, `FPES_CMD_BYP_RST1);
								seq_q[1] <= cyc(20'h00000, `FPES_CMD_BYP_RST2);
								len_q <= 3'h2;
							end
							FPES_OP_CHIP_ERASE, FPES_OP_SECTOR_ERASE: begin
								seq_q[2] <= cyc(`FPES_UNLOCK1_ADDR, `FPES_CMD_ERASE_SETUP);
								seq_q[3] <= cyc(`FPES_UNLOCK1_ADDR, `FPES_UNLOCK1_DATA);
								seq_q[4] <= cyc(`FPES_UNLOCK2_ADDR, `FPES_UNLOCK2_DATA);
								if (reqCmd.op == FPES_OP_CHIP_ERASE) begin
									seq_q[5] <= cyc(`FPES_UNLOCK1_ADDR, `FPES_CMD_CHIP_ERASE);
									waitBusy_q <= 1'b1;
								end else begin
									seq_q[5] <= cyc(reqCmd.addr, `FPES_CMD_SECTOR_ERASE);
								end
								len_q <= 3'h6;
							end
							FPES_OP_SECTOR_ADD: begin
								seq_q[0] <= cyc(reqCmd.addr, `FPES_CMD_SECTOR_ERASE);
								len_q <= 3'h1;
							end
							FPES_OP_SUSPEND: begin
								seq_q[0] <= cyc(20'h00000, `FPES_CMD_SUSPEND);
								len_q <= 3'h1;
							end
							FPES_OP_RESUME: begin
								seq_q[0] <= cyc(20'h00000, `FPES_CMD_RESUME);
								len_q <= 3'h1;
							end
							FPES_OP_RESET: begin
								rstCnt_q <= 16'(RST_CYC);
								state_q <= FPES_RESET;
							end
							default: begin
								seq_q[0] <= cyc(20'h00000, `FPES_CMD_RESET);
								len_q <= 3'h1;
							end
						endcase
					end
				end
				FPES_GAP: begin
					if (!wcBusy) begin
						state_q <= FPES_WRITE;
					end
				end
				FPES_WRITE: begin
					if (wcDone) begin
						if (idx_q == len_q - 3'h1) begin
							settle_q <= `FPES_SETTLE_CYC;
							state_q <= waitBusy_q ? FPES_WAIT : FPES_IDLE;
						end else begin
							idx_q <= idx_q + 3'h1;
							state_q <= FPES_GAP;
						end
					end
				end
				FPES_WAIT: begin
					// Busy pin may lag the last strobe; hold off a few cycles
					if (settle_q != 3'h0) begin
						settle_q <= settle_q - 3'h1;
					end else if (ready_busy_n) begin
						state_q <= FPES_IDLE;
					end
				end
				FPES_RESET: begin
					if (rstCnt_q == 16'h0000) begin
						state_q <= FPES_IDLE;
					end else begin
						rstCnt_q <= rstCnt_q - 16'h0001;
					end
				end
				default: begin
					state_q <= FPES_IDLE;
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// Flash pins
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flashCeN <= 1'b1;
			flashWeN <= 1'b1;
			flashOeN <= 1'b1;
			flashResetN <= 1'b1;
			flashAddr <= '0;
			flashDataOut <= 16'h0000;
			flashDataOe <= 1'b0;
			reqReady <= 1'b0;
		end else begin
			flashCeN <= !wcLow;
			flashWeN <= !wcLow;
			flashOeN <= 1'b1; // Output enable stays high so writes are never inhibited
			flashResetN <= (state_q != FPES_RESET);
			flashAddr <= seq_q[idx_q].addr[ADDR_W-1:0];
			flashDataOut <= seq_q[idx_q].data;
			flashDataOe <= (state_q == FPES_WRITE) || (state_q == FPES_GAP);
			reqReady <= (state_q == FPES_IDLE) && !reqValid;
		end
	end
	// ------------------------------------------------------------
	// Mode tracking
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bypassActive <= 1'b0;
			suspended <= 1'b0;
			winOpen <= 1'b0;
			win_q <= 32'h0;
			opFailed <= 1'b0;
		end else if (state_q == FPES_RESET) begin
			bypassActive <= 1'b0;
			suspended <= 1'b0;
			winOpen <= 1'b0;
		end else begin
			if (state_q == FPES_IDLE && reqValid) begin
				case (reqCmd.op)
					FPES_OP_BYPASS_ENTER: bypassActive <= 1'b1;
					FPES_OP_BYPASS_EXIT: bypassActive <= 1'b0;
					FPES_OP_SUSPEND: begin
						suspended <= 1'b1;
						winOpen <= 1'b0;
					end
					FPES_OP_RESUME: suspended <= 1'b0;
					FPES_OP_SECTOR_ERASE, FPES_OP_SECTOR_ADD: begin
						winOpen <= 1'b1;
						win_q <= 32'(WIN_CYC);
					end
					FPES_OP_RESET: opFailed <= 1'b0;
					default: winOpen <= 1'b0;
				endcase
			end else if (winOpen) begin
				if (!flashWeN) begin
					// Window runs from the rise of the last strobe, so reload while a strobe is low
					win_q <= 32'(WIN_CYC);
				end else if (win_q == 32'h0) begin
					winOpen <= 1'b0;
				end else begin
					win_q <= win_q - 32'h1;
				end
			end
			// Time-limit bit seen while busy in the wait state marks a failed program or chip erase
			if (state_q == FPES_WAIT && !ready_busy_n && flashDataIn[`FPES_TIME_LIMIT_BIT]) begin
				opFailed <= 1'b1;
			end
		end
	end
endmodule : fpes_host
`default_nettype wire

// File: sim/fpes_host_checker.sv
// Pin-level assertions for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module fpes_host_checker #(
	parameter int ADDR_W = 20,
	parameter int RST_CYC = 100
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic reqReady,
	input wire logic flashCeN,
	input wire logic flashWeN,
	input wire logic flashOeN,
	input wire logic flashResetN,
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic [15:0] flashDataOut,
	input wire logic flashDataOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Counts low cycles of the flash reset pulse
	int rstCnt_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstCnt_q <= 0;
		end else begin
			rstCnt_q <= flashResetN ? 0 : rstCnt_q + 1;
		end
	end
	AST_CE_WE: assert property (flashCeN == flashWeN) else $error("strobes differ");
	AST_OE_HIGH: assert property (flashOeN) else $error("output enable low");
	AST_LOW7: assert property ($fell(flashWeN) |-> !flashWeN [*7] ##1 flashWeN) else $error("strobe width");
	AST_HIGH4: assert property ($rose(flashWeN) |-> flashWeN [*4]) else $error("strobe gap");
	AST_HOLD: assert property (!flashWeN && !$past(flashWeN) |-> $stable({flashAddr, flashDataOut}) && flashDataOe)
		else $error("bus moved in write");
	AST_RST_LEN: assert property ($rose(flashResetN) |-> rstCnt_q == RST_CYC + 1) else $error("reset length");
	AST_QUIET_RST: assert property (!flashResetN |-> flashWeN) else $error("write in reset");
	AST_IDLE: assert property (reqReady |-> flashWeN && flashResetN) else $error("busy while ready");
endmodule : fpes_host_checker
bind fpes_host fpes_host_checker #(.ADDR_W(ADDR_W), .RST_CYC(RST_CYC)) chk (.clk(clk), .nrst(nrst),
	.reqReady(reqReady), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
	.flashResetN(flashResetN), .flashAddr(flashAddr), .flashDataOut(flashDataOut), .flashDataOe(flashDataOe));
`default_nettype wire

// File: sim/fpes_flash_model.sv
// Behavioural flash that decodes command writes and reports busy
`timescale 1ns/100ps
`default_nettype none
module fpes_flash_model #(
	parameter int BUSY_CYC = 40
) (
	input wire logic clk,
	input wire logic flashWeN,
	input wire logic flashResetN,
	input wire logic [15:0] flashDataOut,
	input wire logic failArm,
	output logic ready_busy_n,
	output logic [15:0] flashDataIn
);
	int busyCnt = 0;
	int heldCnt = 0;
	logic weQ = 1'b1, pend = 1'b0, sect = 1'b0, susp = 1'b0, fail = 1'b0;
	logic [7:0] prev = 8'h00;
	logic [7:0] cmd;
	assign cmd = flashDataOut[7:0];
	assign ready_busy_n = (busyCnt == 0);
	assign flashDataIn = {9'h000, busyCnt[0], fail, 5'h00};
	always @(posedge clk) begin
		weQ <= flashWeN;
		if (!flashResetN) begin
			busyCnt <= 0;
			heldCnt <= 0;
			pend <= 1'b0;
			sect <= 1'b0;
			susp <= 1'b0;
			fail <= 1'b0;
		end else if (flashWeN && !weQ) begin
			prev <= cmd;
			if (busyCnt != 0) begin
				// A suspend during a sector erase parks the remaining count; all else, extra sectors too, is ignored
				if (sect && cmd == 8'hb0) begin
					heldCnt <= busyCnt;
					busyCnt <= 0;
					susp <= 1'b1;
				end
			end else if (pend) begin
				pend <= 1'b0;
				busyCnt <= BUSY_CYC;
				fail <= failArm;
			end else if (cmd == 8'ha0) begin
				pend <= 1'b1;
			end else if (cmd == 8'h30 && susp) begin
				susp <= 1'b0;
				busyCnt <= heldCnt;
				heldCnt <= 0;
			end else if (cmd == 8'h10 && prev == 8'h55) begin
				busyCnt <= 2 * BUSY_CYC;
			end else if (cmd == 8'h30 && prev == 8'h55) begin
				sect <= 1'b1;
				busyCnt <= 4 * BUSY_CYC;
			end
		end else if (busyCnt != 0) begin
			busyCnt <= busyCnt - 1;
			if (busyCnt == 1 && heldCnt == 0) begin
				sect <= 1'b0;
			end
		end
	end
endmodule : fpes_flash_model
`default_nettype wire

// File: sim/tb_flash_program_erase_sequencer.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_flash_program_erase_sequencer;
	import fpes_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, reqValid = 1'b0, failArm = 1'b0, weSeen = 1'b1;
	fpes_req_t reqCmd = '0;
	logic reqReady, opFailed, bypassActive, suspended, winOpen, flashCeN, flashWeN, flashOeN;
	logic flashResetN, flashDataOe, ready_busy_n;
	logic [19:0] flashAddr;
	logic [15:0] flashDataOut, flashDataIn;
	int error_cnt = 0, compares = 0;
	logic [31:0] lfsrQ = 32'h4304bea0;
	logic [36:0] expQ[$];
	always #2.5 clk = ~clk;
	fpes_host #(.WIN_CYC(50), .RST_CYC(8)) dut (.clk(clk), .nrst(nrst), .reqCmd(reqCmd), .reqValid(reqValid),
		.reqReady(reqReady), .opFailed(opFailed), .bypassActive(bypassActive), .suspended(suspended),
		.winOpen(winOpen), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
		.flashResetN(flashResetN), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
		.flashDataOe(flashDataOe), .flashDataIn(flashDataIn), .ready_busy_n(ready_busy_n));
	fpes_flash_model flash (.clk(clk), .flashWeN(flashWeN), .flashResetN(flashResetN),
		.flashDataOut(flashDataOut), .failArm(failArm), .ready_busy_n(ready_busy_n), .flashDataIn(flashDataIn));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic fail(input string msg);
		$display("CHECK FAILED %0t %s", $time, msg);
		error_cnt++;
	endtask : fail
	task automatic chk_flag(input logic got, input logic exp);
		compares++;
		if (got !== exp) fail("flag");
	endtask : chk_flag
	// Command writes check only the low byte, the upper one is free
	task automatic chk_write(input logic [36:0] e);
		compares++;
		if (flashAddr !== e[35:16] || (e[36] ? flashDataOut !== e[15:0] : flashDataOut[7:0] !== e[7:0])) fail("write");
	endtask : chk_write
	task automatic want(input logic full, input logic [19:0] a, input logic [15:0] d);
		expQ.push_back({full, a, d});
	endtask : want
	task automatic unlock();
		want(1'b0, 20'h00555, 16'h00aa);
		want(1'b0, 20'h002aa, 16'h0055);
	endtask : unlock
	task automatic order(input fpes_op_t op, input logic [19:0] a, input logic [15:0] d);
		int n;
		@(posedge clk) #1;
		reqCmd = {op, a, d};
		reqValid = 1'b1;
		@(posedge clk) #1;
		reqValid = 1'b0;
		n = 0;
		while (reqReady !== 1'b1 && n < 20000) begin
			@(posedge clk) #1;
			n++;
		end
		if (n >= 20000) fail("no ready");
		chk_flag(expQ.size() == 0, 1'b1);
	endtask : order
	task automatic close_out();
		if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// Each write is judged on its first low cycle
	always @(posedge clk) begin
		weSeen <= flashWeN;
		if (nrst && !flashWeN && weSeen) begin
			if (expQ.size() == 0) fail("extra write");
			else chk_write(expQ.pop_front());
		end
	end
	initial begin
		#200000;
		fail("timeout");
		close_out();
	end
	initial begin
		logic [19:0] a;
		logic [15:0] d;
		int n;
		repeat (4) @(posedge clk);
		#1 nrst = 1'b1;
		want(1'b0, 20'h00000, 16'h00f0);
		order(fpes_op_t'(4'hf), '0, '0);
		for (int i = 0; i < 5; i++) begin
			lfsrQ = lfsr(lfsrQ);
			a = lfsrQ[19:0];
			d = lfsrQ[31:16];
			failArm = (i == 2);
			if (i == 3) begin
				unlock();
				want(1'b0, 20'h00555, 16'h0020);
				order(FPES_OP_BYPASS_ENTER, '0, '0);
				chk_flag(bypassActive, 1'b1);
			end
			if (i < 3) begin
				unlock();
				want(1'b0, 20'h00555, 16'h00a0);
			end else begin
				want(1'b0, 20'h00000, 16'h00a0);
			end
			want(1'b1, a, d);
			order(i < 3 ? FPES_OP_PROGRAM : FPES_OP_BYPASS_PROGRAM, a, d);
			chk_flag(ready_busy_n, 1'b1);
			chk_flag(opFailed, i >= 2);
		end
		chk_flag(bypassActive, 1'b1);
		want(1'b0, 20'h00000, 16'h0090);
		want(1'b0, 20'h00000, 16'h0000);
		order(FPES_OP_BYPASS_EXIT, '0, '0);
		chk_flag(bypassActive, 1'b0);
		order(FPES_OP_RESET, '0, '0);
		chk_flag(opFailed, 1'b0);
		for (int i = 0; i < 2; i++) begin
			unlock();
			want(1'b0, 20'h00555, 16'h0080);
			unlock();
			want(1'b0, i ? 20'h3f000 : 20'h00555, i ? 16'h0030 : 16'h0010);
			order(i ? FPES_OP_SECTOR_ERASE : FPES_OP_CHIP_ERASE, 20'h3f000, '0);
		end
		chk_flag(winOpen, 1'b1);
		want(1'b0, 20'h1e000, 16'h0030);
		order(FPES_OP_SECTOR_ADD, 20'h1e000, '0);
		want(1'b0, 20'h00000, 16'h00b0);
		order(FPES_OP_SUSPEND, '0, '0);
		chk_flag(suspended, 1'b1);
		chk_flag(winOpen, 1'b0);
		unlock();
		want(1'b0, 20'h00555, 16'h00a0);
		want(1'b1, 20'h00040, 16'h1234);
		order(FPES_OP_PROGRAM, 20'h00040, 16'h1234);
		chk_flag(suspended, 1'b1);
		want(1'b0, 20'h00000, 16'h0030);
		order(FPES_OP_RESUME, '0, '0);
		chk_flag(suspended, 1'b0);
		chk_flag(ready_busy_n, 1'b0);
		n = 0;
		while (ready_busy_n !== 1'b1 && n < 5000) begin
			@(posedge clk) #1;
			n++;
		end
		chk_flag(ready_busy_n, 1'b1);
		unlock();
		want(1'b0, 20'h00555, 16'h0080);
		unlock();
		want(1'b0, 20'h2b000, 16'h0030);
		order(FPES_OP_SECTOR_ERASE, 20'h2b000, '0);
		repeat (40) @(posedge clk) #1;
		chk_flag(winOpen, 1'b1);
		repeat (10) @(posedge clk) #1;
		chk_flag(winOpen, 1'b0);
		close_out();
	end
endmodule : tb_flash_program_erase_sequencer
`default_nettype wire
